// ### inc/prf_pkg.sv
// Purpose: Constants and types for the upper physical request filter block.
// Assumes: 32-bit AHB-Lite register bus, 16-bit serial bus node IDs.
// Notes: Source ID is bus number in [15:6] and node number in [5:0].
package prf_pkg;

  // Register byte addresses
  localparam logic [11:0] PRF_SET_OFFSET = 12'h110;
  localparam logic [11:0] PRF_CLR_OFFSET = 12'h114;
  localparam int PRF_ADDR_W = 12;

  // Register reset value and field positions
  localparam logic [31:0] PRF_FILTER_RESET = 32'h0000_0000;
  localparam int PRF_REMOTE_BIT = 31;
  localparam int PRF_NODE_BITS = 31;
  localparam logic [5:0] PRF_FIRST_NODE = 6'h20;
  localparam logic [5:0] PRF_BCAST_NODE = 6'h3F;

  // Node ID layout
  localparam int PRF_NODE_W = 6;
  localparam int PRF_BUS_W = 10;
  localparam logic [9:0] PRF_LOCAL_BUS_ALIAS = 10'h3FF;

  // AHB encodings
  localparam logic [1:0] PRF_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PRF_HSIZE_WORD = 3'h2;

  // Routing decisions
  typedef enum logic [2:0] {
    PRF_RT_NONE,
    PRF_RT_PHYS,
    PRF_RT_ASYNC,
    PRF_RT_DROP,
    PRF_RT_LOWER
  } prf_route_e;

endpackage

// ### inc/prf_route_if.sv
// Purpose: Carries a request and the filter word into the routing stage.
// Assumes: Same clock on both sides.
// Notes: Result fields are registered inside the routing stage.
`timescale 1ns/1ps
interface prf_route_if;
  import prf_pkg::*;
  logic req_valid; // Request present this cycle
  logic req_to_phys; // Request aims at the physical request context
  logic req_async_ok; // First stage accepted the source node
  logic [15:0] req_src_id; // Source node ID
  logic [9:0] local_bus; // Our own bus number
  logic [31:0] filter; // Current filter word
  logic res_valid; // Decision valid
  prf_route_e res_route; // Decision

  modport ctrl (output req_valid, req_to_phys, req_async_ok, req_src_id, local_bus, filter,
                input res_valid, res_route);
  modport route (input req_valid, req_to_phys, req_async_ok, req_src_id, local_bus, filter,
                 output res_valid, res_route);
endinterface

// ### logic/prf_route.sv
// Purpose: Routing stage, decides where one incoming request goes.
// Assumes: Request inputs come from logic on the same clock.
// Notes: Decision appears one clock after the request.
`timescale 1ns/1ps
module prf_route
  import prf_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Request and decision
  prf_route_if.route rif
);

  // Registered state
  typedef struct packed {
    logic valid;
    prf_route_e route;
  } prf_rstate_s;

  prf_rstate_s state_ff;
  prf_rstate_s nxt_state;

  // Looks up the enable bit of a node from 32 to 62
  function automatic logic prf_node_enabled(input logic [31:0] f, input logic [5:0] node);
    logic [5:0] idx;
    idx = node - PRF_FIRST_NODE;
    return f[idx[4:0]];
  endfunction

  // Next decision
  always_comb begin
    logic [9:0] bus;
    logic [5:0] node;
    logic local_src;
    bus = rif.req_src_id[15:6];
    node = rif.req_src_id[5:0];
    local_src = (bus == rif.local_bus) || (bus == PRF_LOCAL_BUS_ALIAS);
    nxt_state.valid = rif.req_valid;
    nxt_state.route = PRF_RT_NONE;
    if (!rif.req_valid) begin
      nxt_state.route = PRF_RT_NONE;
    end else if (!local_src) begin
      // Remote sources skip the per-node compare
      if (!rif.filter[PRF_REMOTE_BIT]) begin
        nxt_state.route = PRF_RT_DROP;
      end else if (rif.req_to_phys) begin
        nxt_state.route = PRF_RT_PHYS;
      end else begin
        nxt_state.route = PRF_RT_ASYNC;
      end
    end else if (!rif.req_async_ok) begin
      nxt_state.route = PRF_RT_DROP;
    end else if (!rif.req_to_phys) begin
      nxt_state.route = PRF_RT_ASYNC;
    end else if (node < PRF_FIRST_NODE) begin
      nxt_state.route = PRF_RT_LOWER;
    end else if (node == PRF_BCAST_NODE) begin
      nxt_state.route = PRF_RT_ASYNC;
    end else if (prf_node_enabled(rif.filter, node)) begin
      nxt_state.route = PRF_RT_PHYS;
    end else begin
      nxt_state.route = PRF_RT_ASYNC;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{valid: 1'b0, route: PRF_RT_NONE};
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign rif.res_valid = state_ff.valid;
  assign rif.res_route = state_ff.route;

endmodule

// ### logic/prf_top.sv
// Purpose: Upper physical request filter with AHB-Lite register access.
// Assumes: Single whole-word transfers, one clock, request inputs on clk.
// Notes: Bit 31 accepts remote bus requests, bits 30..0 enable nodes 32..62.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module prf_top
  import prf_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Primary reset pin, active low, asynchronous to clk
  input wire logic primary_reset_pin_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Incoming request from the link layer
  input wire logic req_valid,
  input wire logic req_to_phys,
  input wire logic req_async_ok,
  input wire logic [15:0] req_src_id,
  input wire logic [9:0] local_bus_id,
  // Routing decision
  output logic route_valid,
  output logic route_phys,
  output logic route_async,
  output logic route_drop,
  output logic route_lower,
  // Filter state for the rest of the controller
  output logic accept_remote_bus_requests,
  output logic [30:0] per_node_physical_enable
);

  // Reset release synchroniser, first stage read only by second
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Register state of this module apart from the reset synchroniser
  typedef struct packed {
    logic primary_reset_pin_meta; // Pin sampler stage one
    logic primary_reset_pin_sync; // Pin sampler stage two
    logic ph_valid; // Data phase pending
    logic ph_write; // Pending phase is a write
    logic ph_set; // Pending phase hits the set view
    logic ph_clr; // Pending phase hits the clear view
    logic [31:0] filter; // Filter register
    logic [31:0] rdata; // Read data for the bus
    logic r_valid; // Decision outputs
    logic r_phys;
    logic r_async;
    logic r_drop;
    logic r_lower;
  } prf_state_s;

  prf_state_s state_ff;
  prf_state_s nxt_state;

  // Link to the routing stage
  prf_route_if rif ();

  // Routing stage
  prf_route u_route (
    .clk(clk),
    .rst_n(rst_sync_ff),
    .ce(ce),
    .rif(rif)
  );

  // Drive the routing stage inputs
  assign rif.req_valid = req_valid;
  assign rif.req_to_phys = req_to_phys;
  assign rif.req_async_ok = req_async_ok;
  assign rif.req_src_id = req_src_id;
  assign rif.local_bus = local_bus_id;
  assign rif.filter = state_ff.filter;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Next state of bus slave, filter and decision outputs
  always_comb begin
    logic addr_take;
    logic [11:0] offs;
    logic [31:0] filt;
    logic hit_set;
    logic hit_clr;
    nxt_state = state_ff;
    // Pin sampler
    nxt_state.primary_reset_pin_meta = primary_reset_pin_n;
    nxt_state.primary_reset_pin_sync = state_ff.primary_reset_pin_meta;
    // Data phase of a pending write
    filt = state_ff.filter;
    if (state_ff.ph_valid && state_ff.ph_write) begin
      if (state_ff.ph_set) begin
        filt = filt | hwdata;
      end else if (state_ff.ph_clr) begin
        filt = filt & ~hwdata;
      end
    end
    // Primary reset clears node bits but keeps the remote bit
    if (!state_ff.primary_reset_pin_sync) begin
      filt[PRF_NODE_BITS-1:0] = PRF_FILTER_RESET[PRF_NODE_BITS-1:0];
    end
    nxt_state.filter = filt;
    // Address phase decode
    addr_take = hsel && hready && (htrans == PRF_HTRANS_NONSEQ);
    offs = haddr[PRF_ADDR_W-1:0];
    hit_set = 1'b0;
    hit_clr = 1'b0;
    if (haddr[31:PRF_ADDR_W] != '0) begin
      hit_set = 1'b0;
    end else if (offs == PRF_SET_OFFSET) begin
      hit_set = 1'b1;
    end else if (offs == PRF_CLR_OFFSET) begin
      hit_clr = 1'b1;
    end
    nxt_state.ph_valid = addr_take;
    nxt_state.ph_write = addr_take && hwrite;
    nxt_state.ph_set = addr_take && hit_set;
    nxt_state.ph_clr = addr_take && hit_clr;
    // Read data reflects the value after any write in flight
    if (addr_take && !hwrite && (hit_set || hit_clr)) begin
      nxt_state.rdata = filt;
    end else begin
      nxt_state.rdata = 32'h0000_0000;
    end
    // Decode routing stage result into one-hot flags
    nxt_state.r_valid = rif.res_valid;
    nxt_state.r_phys = rif.res_valid && (rif.res_route == PRF_RT_PHYS);
    nxt_state.r_async = rif.res_valid && (rif.res_route == PRF_RT_ASYNC);
    nxt_state.r_drop = rif.res_valid && (rif.res_route == PRF_RT_DROP);
    nxt_state.r_lower = rif.res_valid && (rif.res_route == PRF_RT_LOWER);
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= '0;
      state_ff.filter <= PRF_FILTER_RESET;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flip-flops, hreadyout and hresp tied to constants
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_ff.rdata;
  assign route_valid = state_ff.r_valid;
  assign route_phys = state_ff.r_phys;
  assign route_async = state_ff.r_async;
  assign route_drop = state_ff.r_drop;
  assign route_lower = state_ff.r_lower;
  assign accept_remote_bus_requests = state_ff.filter[PRF_REMOTE_BIT];
  assign per_node_physical_enable = state_ff.filter[PRF_NODE_BITS-1:0];

endmodule

// ### verification/prf_top_properties.sv
// Purpose: Concurrent checks on the filter ports.
// Assumes: One clock, ce driven by the bench and low for one stretch with no request.
// Notes: Decisions are looked at two edges after the taking edge.
`timescale 1ns/1ps
module prf_top_properties
  import prf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus and request side
  input wire logic ce,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic req_valid,
  input wire logic req_to_phys,
  input wire logic req_async_ok,
  input wire logic [15:0] req_src_id,
  input wire logic [9:0] local_bus_id,
  // Decision and filter state
  input wire logic route_valid,
  input wire logic route_phys,
  input wire logic route_async,
  input wire logic route_drop,
  input wire logic route_lower,
  input wire logic accept_remote_bus_requests,
  input wire logic [30:0] per_node_physical_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Taken request, and whether its source sits on our bus
  wire logic tk = req_valid && ce;
  wire logic loc = req_src_id[15:6] == local_bus_id || req_src_id[15:6] == PRF_LOCAL_BUS_ALIAS;
  wire logic [5:0] nd = req_src_id[5:0];
  // Local request that passed the first stage towards physical
  wire logic go = tk && loc && req_async_ok && req_to_phys;
  // Enable bit of the source node, valid for nodes 32 to 62 only
  wire logic en = per_node_physical_enable[5'(nd - PRF_FIRST_NODE)];
  wire logic up = nd >= PRF_FIRST_NODE && nd != PRF_BCAST_NODE;
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not OKAY");
  a_flag_onehot: assert property (route_valid |-> $onehot({route_phys, route_async,
    route_drop, route_lower})) else $error("flags not one-hot");
  a_route_delay: assert property (tk |-> ##2 route_valid) else $error("late decision");
  a_remote_drop: assert property (tk && !loc && !accept_remote_bus_requests |-> ##2 route_drop)
    else $error("remote not dropped");
  a_remote_pass: assert property (tk && !loc && accept_remote_bus_requests && req_to_phys
    |-> ##2 route_phys) else $error("remote not passed");
  a_first_stage: assert property (tk && loc && !req_async_ok |-> ##2 route_drop)
    else $error("first stage ignored");
  a_node_filter: assert property (go && up |-> ##2 route_phys == $past(en, 2))
    else $error("node bit ignored");
  a_lower_node: assert property (go && nd < PRF_FIRST_NODE |-> ##2 route_lower)
    else $error("low node not passed on");
endmodule
bind prf_top prf_top_properties prf_top_properties_i (.clk, .rstn, .ce, .hreadyout, .hresp,
  .req_valid, .req_to_phys, .req_async_ok, .req_src_id, .local_bus_id, .route_valid,
  .route_phys, .route_async, .route_drop, .route_lower, .accept_remote_bus_requests,
  .per_node_physical_enable);

// ### verification/prf_node_model.sv
// Purpose: Serial bus nodes handing requests to the filter.
// Assumes: One request per call, on clk.
// Notes: Fields show inverted values after the taking cycle, zero before the first call.
`timescale 1ns/1ps
module prf_node_model (
  // Clock
  input wire logic clk,
  // Request to the filter
  output logic req_valid = 1'b0,
  output logic req_to_phys = 1'b0,
  output logic req_async_ok = 1'b0,
  output logic [15:0] req_src_id = 16'h0
);
  // Hold a request for one edge, then scramble the fields
  task automatic issue(input logic [15:0] s, input logic p, input logic a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_src_id <= s;
    req_to_phys <= p;
    req_async_ok <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    req_src_id <= ~s;
    req_to_phys <= ~p;
    req_async_ok <= ~a;
  endtask
endmodule

// ### verification/prf_top_test.sv
// Purpose: Register and routing tests for the upper physical filter.
// Assumes: Single word AHB-Lite transfers, ce high except for one frozen stretch.
// Notes: Flags compare as {phys, async, drop, lower}.
`timescale 1ns/1ps
`define CK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module prf_top_test;
  import prf_pkg::*;
  // Bench driven inputs
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic primary_reset_pin_n = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] local_bus_id = 10'h005;
  // Design outputs and model lines
  logic hreadyout, hresp, req_valid, req_to_phys, req_async_ok, route_valid;
  logic route_phys, route_async, route_drop, route_lower, accept_remote_bus_requests;
  logic [31:0] hrdata, rd;
  logic [15:0] req_src_id;
  logic [30:0] per_node_physical_enable;
  int n_mismatch = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  prf_top prf_top_i (.clk, .rstn, .ce, .primary_reset_pin_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(PRF_HSIZE_WORD), .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata,
    .req_valid, .req_to_phys, .req_async_ok, .req_src_id, .local_bus_id, .route_valid,
    .route_phys, .route_async, .route_drop, .route_lower, .accept_remote_bus_requests,
    .per_node_physical_enable);
  prf_node_model prf_node_model_i (.clk, .req_valid, .req_to_phys, .req_async_ok, .req_src_id);
  // Verdict and end of run
  task automatic results;
    $display("Compared %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin n_mismatch++; results(); end
  endtask
  // One single word transfer, read data left in rd
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PRF_HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // One request, then its decision against the expected flags
  task automatic rq(input logic [15:0] s, input logic p, input logic a, input logic [3:0] e);
    int k;
    prf_node_model_i.issue(s, p, a);
    k = 0;
    while (route_valid !== 1'b1 && k < 8) begin @(posedge clk); k++; end
    if (route_valid !== 1'b1) begin n_mismatch++; results(); end
    `CK({route_phys, route_async, route_drop, route_lower}, e)
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(1'b0, 32'h110, 32'h0);
    `CK(rd, PRF_FILTER_RESET)
    ahb(1'b1, 32'h110, 32'hC000_0001);
    ahb(1'b0, 32'h114, 32'h0);
    `CK(rd, 32'hC000_0001)
    ahb(1'b1, 32'h114, 32'h0000_0001);
    ahb(1'b0, 32'h110, 32'h0);
    `CK(rd, 32'hC000_0000)
    `CK({accept_remote_bus_requests, per_node_physical_enable}, 32'hC000_0000)
    ahb(1'b1, 32'h118, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h118, 32'h0);
    `CK(rd, 32'h0)
    rq(16'h017E, 1'b1, 1'b1, 4'h8);
    rq(16'h0160, 1'b1, 1'b1, 4'h4);
    rq(16'h017E, 1'b1, 1'b0, 4'h2);
    rq(16'h017E, 1'b0, 1'b1, 4'h4);
    rq(16'hFFFE, 1'b1, 1'b1, 4'h8);
    rq(16'h0145, 1'b1, 1'b1, 4'h1);
    rq(16'h017F, 1'b1, 1'b1, 4'h4);
    rq(16'h01E0, 1'b1, 1'b0, 4'h8);
    ahb(1'b1, 32'h114, 32'h8000_0000);
    rq(16'h01E0, 1'b1, 1'b1, 4'h2);
    ahb(1'b1, 32'h110, 32'h8000_00FF);
    primary_reset_pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    primary_reset_pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(1'b0, 32'h114, 32'h0);
    `CK(rd, 32'h8000_0000)
    // Clock enable low freezes the filter even while the pin is asserted
    ahb(1'b1, 32'h110, 32'h0000_0004);
    ce <= 1'b0;
    primary_reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    primary_reset_pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CK(per_node_physical_enable, 31'h0000_0004)
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    `CK({accept_remote_bus_requests, per_node_physical_enable}, 32'h8000_0004)
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(1'b0, 32'h110, 32'h0);
    `CK(rd, PRF_FILTER_RESET)
    results();
  end
endmodule
